// File: include/cca_map.svh
// constants of the rail a charge counter readout: register indices,
// field positions, reset values and the few timing figures.
// assumes a host on avalon-mm with byte addresses, index times four.
//
// Contract
// RULE_01: rail a mode in bits 1:0, read-only
// RULE_02: firmware calibrates with converter held in one mode
// RULE_03: firmware recomputes charge per pulse on mode change
// RULE_04: mode register frozen while it is addressed
// RULE_05: sixteen-bit count as high and low bytes
// RULE_06: count advances once per prescaled pulse group
// RULE_07: counter frozen while a byte is addressed
// RULE_08: firmware addresses counter only while reading it
// RULE_09: high byte read copies low byte to shadow
// RULE_10: low byte read returns the shadow copy
// RULE_11: writes to read-only registers change nothing
// RULE_12: counting resumes after access; frozen pulses dropped
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// register indices; byte address is four times the index
`define CCA_IDX_CTRL      6'h10
`define CCA_IDX_MODE      6'h11
`define CCA_IDX_CNT_HI    6'h13
`define CCA_IDX_CNT_LO    6'h14

// field positions
`define RAIL_A_CONVERTER_MODE_MSB      1
`define RAIL_A_CONVERTER_MODE_LSB      0
`define CCA_PS_MSB        1
`define CCA_PS_LSB        0

// reset values
`define CCA_RST_COUNT     16'h0000
`define CCA_RST_SHADOW    8'h00
`define CCA_RST_MODE      2'h0
`define CCA_RST_PS        2'h0

// widths
`define CCA_ADDR_W        8
`define CCA_DATA_W        32
`define CCA_PS_CNT_W      3

// timing: wait states before the bus answer, synchroniser depth
`define CCA_WAIT_STATES   1
`define CCA_SYNC_STAGES   2

`endif

// File: include/cca_pkg.sv
// types shared by the rail a charge counter readout files.
// assumes cca_map.svh is on the include path.
`include "cca_map.svh"

package cca_pkg;

    // converter mode of rail a, codes 0..3 in declaration order
    typedef enum logic [1:0] {
        RAIL_A_CONVERTER_MODE_BUCK,
        RAIL_A_CONVERTER_MODE_AUTO,
        RAIL_A_CONVERTER_MODE_BOOST,
        RAIL_A_CONVERTER_MODE_LDO
    } rail_a_converter_mode_e;

    // avalon slave handshake state
    typedef enum logic {
        CCA_BUS_IDLE,
        CCA_BUS_ACK
    } cca_bus_e;

    // avalon-mm request from the host
    typedef struct packed {
        logic [`CCA_ADDR_W-1:0]   address;
        logic                     read;
        logic                     write;
        logic [`CCA_DATA_W-1:0]   writedata;
        logic [3:0]               byteenable;
    } cca_avreq_s;

endpackage

// File: rtl/cca_sync2.sv
// two flip-flop synchroniser for levels arriving from pins.
// assumes the input is quasi-static against ref_clk or a slow pulse.
`timescale 1ns/1ps

module cca_sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;   // first stage, read only by the second
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // next values: plain shift
    always_comb
    begin
        meta_d = d;
        q_d    = meta_q;
    end

    // registers only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule // cca_sync2

// File: rtl/cca_prescale.sv
// pulse prescaler: one done pulse per group of 2**sel input pulses.
// assumes pulse is a one-cycle strobe on ref_clk.
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_prescale (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       pulse,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            done
);
    logic [`CCA_PS_CNT_W-1:0] cnt_q;    // pulses seen in this group
    logic [`CCA_PS_CNT_W-1:0] cnt_d;
    logic [`CCA_PS_CNT_W-1:0] last;     // group size minus one
    logic                     done_d;

    // group bookkeeping; pulses while stopped are simply dropped
    always_comb
    begin
        last   = `CCA_PS_CNT_W'((1 << sel) - 1);
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (pulse && run)
        begin
            if (cnt_q >= last)
            begin
                cnt_d  = '0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + `CCA_PS_CNT_W'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            done  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            done  <= done_d;
        end
    end
endmodule // cca_prescale

// File: rtl/cca_charge_readout.sv
// rail a charge counter readout: mode status, sixteen-bit pulse count
// with a coherent high/low byte pair, and an avalon-mm slave.
// assumes conv_pulse and conv_mode come from the converter, unsynced,
// and that the host is an avalon-mm master on ref_clk (40 mhz).
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_charge_readout (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // avalon-mm request bundle from the host
    input  wire cca_pkg::cca_avreq_s    av_req,
    // avalon-mm answer, both registered
    output logic [`CCA_DATA_W-1:0]      av_readdata,
    output logic                        av_waitrequest,
    // converter pulse strobe from rail a, asynchronous
    input  wire logic                   conv_pulse,
    // converter mode of rail a, asynchronous level
    input  wire logic [1:0]             conv_mode
);
    import cca_pkg::*;

    // register index from a byte address; decode is shared by the
    // freeze logic and the read mux so both agree on what is hit
    function automatic logic [5:0] reg_index(
        input logic [`CCA_ADDR_W-1:0] a
    );
        return a[`CCA_ADDR_W-1:2];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic       pulse_sync;     // synchronised pulse level
    logic [1:0] mode_sync;      // synchronised mode code
    logic       pulse_prev_q;   // last pulse level, for edge detect
    logic       pulse_prev_d;
    logic       pulse_rise;     // one-cycle strobe per converter pulse

    // pulse level from the pin
    cca_sync2 #(
        .W (1)
    ) u_sync_pulse (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (conv_pulse),
        .q       (pulse_sync)
    );

    // mode code from the pin; a code may pass through a mixed
    // value for one cycle while its bits change, so the register
    // below only takes a code seen on two edges running
    cca_sync2 #(
        .W (2)
    ) u_sync_mode (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (conv_mode),
        .q       (mode_sync)
    );

    // edge detect on the second stage only
    always_comb
    begin
        pulse_prev_d = pulse_sync;
        pulse_rise   = pulse_sync & ~pulse_prev_q;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_prev_q <= 1'b0;
        end
        else
        begin
            pulse_prev_q <= pulse_prev_d;
        end
    end

    // ------------------------------------------------------------
    // address decode of the live request
    // ------------------------------------------------------------
    logic       req_live;       // read or write held by the master
    logic [5:0] req_idx;        // register index of that request
    logic       hold_mode;      // mode register is being addressed
    logic       hold_count;     // a counter byte is being addressed

    // freezes follow the address for as long as the request stands,
    // not just the answer cycle, so the capture stays stable
    always_comb
    begin
        req_live = av_req.read | av_req.write;
        req_idx  = reg_index(av_req.address);
        // RULE_04 mode freeze decode
        hold_mode = req_live && (req_idx == `CCA_IDX_MODE);
        // RULE_07 counter freeze decode
        hold_count = req_live && ((req_idx == `CCA_IDX_CNT_HI) ||
                                  (req_idx == `CCA_IDX_CNT_LO));
    end

    // ------------------------------------------------------------
    // mode status register
    // ------------------------------------------------------------
    rail_a_converter_mode_e  mode_q;         // captured converter mode
    rail_a_converter_mode_e  mode_d;
    logic [1:0] mode_prev_q;    // code seen on the previous edge
    logic [1:0] mode_prev_d;
    logic       mode_steady;    // same code on two edges running

    // tracks the pin unless the host is looking at it; a code is
    // only taken once steady, so a freeze never keeps a mixed one
    always_comb
    begin
        mode_prev_d = mode_sync;
        mode_steady = (mode_sync == mode_prev_q);
        // RULE_04 hold while addressed
        if (hold_mode || !mode_steady)
        begin
            mode_d = mode_q;
        end
        // RULE_01 sample the mode code
        else
        begin
            mode_d = rail_a_converter_mode_e'(mode_sync);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q      <= rail_a_converter_mode_e'(`CCA_RST_MODE);
            mode_prev_q <= `CCA_RST_MODE;
        end
        else
        begin
            mode_q      <= mode_d;
            mode_prev_q <= mode_prev_d;
        end
    end

    // ------------------------------------------------------------
    // prescaler and sixteen-bit counter
    // ------------------------------------------------------------
    logic [1:0]  ps_sel_q;      // prescale select, host writable
    logic        grp_done;      // one full pulse group seen
    logic [15:0] count_q;       // live pulse-group count
    logic [15:0] count_d;

    // the prescaler is stopped too while frozen, so a partial group
    // does not complete behind the host's back; pulses are lost
    // rather than buffered, trading a few counts for no extra state
    // RULE_06 prescaled pulse groups
    cca_prescale u_prescale (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pulse   (pulse_rise),
        .run     (~hold_count),
        .sel     (ps_sel_q),
        .done    (grp_done)
    );

    // count advance; wraps at the top without a flag
    always_comb
    begin
        count_d = count_q;
        // RULE_07 no update while frozen
        if (hold_count)
        begin
            count_d = count_q;
        end
        // RULE_06 one step per group
        else if (grp_done)
        begin
            count_d = count_q + 16'h0001;
        end
        // RULE_12 resumes once access ends
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= `CCA_RST_COUNT;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // avalon-mm slave: one wait state, then a one-cycle answer
    // ------------------------------------------------------------
    cca_bus_e              bus_q;       // handshake state
    cca_bus_e              bus_d;
    logic [`CCA_DATA_W-1:0] rdata_q;    // registered read data
    logic [`CCA_DATA_W-1:0] rdata_d;
    logic                  wait_q;      // registered waitrequest
    logic                  wait_d;
    logic [7:0]            shadow_q;    // low byte caught by a high read
    logic [7:0]            shadow_d;
    logic [1:0]            ps_sel_d;

    // a request is taken in idle; side effects (shadow capture,
    // control write) happen only there, so a request still held after
    // its answer repeats them at the next answer, two cycles later
    always_comb
    begin
        bus_d    = bus_q;
        rdata_d  = rdata_q;
        wait_d   = wait_q;
        shadow_d = shadow_q;
        ps_sel_d = ps_sel_q;
        unique case (bus_q)
            CCA_BUS_IDLE:
            begin
                // answer one cycle after the request is seen
                if (req_live)
                begin
                    bus_d  = CCA_BUS_ACK;
                    wait_d = 1'b0;
                    // read has priority should both ever appear
                    if (av_req.read)
                    begin
                        unique case (req_idx)
                            `CCA_IDX_CTRL:
                            begin
                                rdata_d = {30'h0, ps_sel_q};
                            end
                            // RULE_01 mode in low bits
                            `CCA_IDX_MODE:
                            begin
                                rdata_d = {30'h0, mode_q};
                            end
                            // RULE_05 upper byte readout
                            `CCA_IDX_CNT_HI:
                            begin
                                rdata_d = {24'h0, count_q[15:8]};
                                // RULE_09 shadow the low byte
                                shadow_d = count_q[7:0];
                            end
                            // RULE_10 low byte from shadow
                            `CCA_IDX_CNT_LO:
                            begin
                                rdata_d = {24'h0, shadow_q};
                            end
                            // unmapped reads return zero
                            default:
                            begin
                                rdata_d = '0;
                            end
                        endcase
                    end
                    // only the control byte takes write data
                    else if ((req_idx == `CCA_IDX_CTRL) &&
                             av_req.byteenable[0])
                    begin
                        ps_sel_d = av_req.writedata[`CCA_PS_MSB:
                                                    `CCA_PS_LSB];
                    end
                    // RULE_11 other writes are dropped
                    else
                    begin
                        ps_sel_d = ps_sel_q;
                    end
                end
            end
            CCA_BUS_ACK:
            begin
                // master samples the answer at this edge and releases
                bus_d  = CCA_BUS_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    // registers only; waitrequest idles high, which avalon allows
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_q    <= CCA_BUS_IDLE;
            rdata_q  <= '0;
            wait_q   <= 1'b1;
            shadow_q <= `CCA_RST_SHADOW;
            ps_sel_q <= `CCA_RST_PS;
        end
        else
        begin
            bus_q    <= bus_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            shadow_q <= shadow_d;
            ps_sel_q <= ps_sel_d;
        end
    end

    // outputs straight from flops
    assign av_readdata    = rdata_q;
    assign av_waitrequest = wait_q;

endmodule // cca_charge_readout

// File: verif/cca_charge_readout_props.sv
// checker for the rail a readout: bus timing, field widths, freezes.
// assumes it is bound to cca_charge_readout and sees only its ports.
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_charge_readout_props (
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire cca_pkg::cca_avreq_s    av_req,
    input wire logic [`CCA_DATA_W-1:0] av_readdata,
    input wire logic                   av_waitrequest,
    input wire logic                   conv_pulse,
    input wire logic [1:0]             conv_mode
);
    import cca_pkg::*;
    logic [5:0] idx;    // register index, byte lanes dropped
    logic       rd_ans; // read answered in this cycle
    assign idx    = av_req.address[7:2];
    assign rd_ans = av_req.read && !av_waitrequest;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // one read held on an index across two answers, two cycles apart
    sequence s_held(logic [5:0] i);
        (rd_ans && idx == i) ##1 (av_req.read && idx == i)
            ##1 (rd_ans && idx == i);
    endsequence
    // a frozen register answers the same value throughout the hold
    property p_frozen(logic [5:0] i);
        s_held(i) |-> av_readdata == $past(av_readdata, 2);
    endproperty

    a_answer_one_wait: assert property (
        (av_req.read || av_req.write) && av_waitrequest
        && $past(av_waitrequest) |=> !av_waitrequest)
        else $error("answer not one cycle after request");
    a_wait_one_cycle: assert property (
        !av_waitrequest |=> av_waitrequest)
        else $error("waitrequest low longer than one cycle");
    // data moves only with an answer
    a_data_on_answer: assert property (
        $changed(av_readdata) |-> !av_waitrequest)
        else $error("read data changed outside an answer");
    a_mode_upper_zero: assert property (
        rd_ans && idx == `CCA_IDX_MODE |-> av_readdata[31:2] == 30'h0)
        else $error("mode read has bits above 1:0");
    a_byte_upper_zero: assert property (
        rd_ans && (idx == `CCA_IDX_CNT_HI || idx == `CCA_IDX_CNT_LO)
        |-> av_readdata[31:8] == 24'h0)
        else $error("count byte read has bits above 7:0");
    a_unmapped_zero: assert property (
        rd_ans && !(idx inside {`CCA_IDX_CTRL, `CCA_IDX_MODE,
        `CCA_IDX_CNT_HI, `CCA_IDX_CNT_LO}) |-> av_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_frozen: assert property (p_frozen(`CCA_IDX_CNT_HI))
        else $error("count moved during a held read");
    a_mode_frozen: assert property (p_frozen(`CCA_IDX_MODE))
        else $error("mode moved during a held read");
endmodule // cca_charge_readout_props

bind cca_charge_readout cca_charge_readout_props
    cca_charge_readout_props_inst (
    .ref_clk(ref_clk), .rst(rst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .conv_pulse(conv_pulse), .conv_mode(conv_mode));

// File: verif/cca_charge_readout_tb.sv
// self-checking bench for the rail a charge counter readout.
// assumes design, package and checker are compiled before it.
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_charge_readout_tb;
    import cca_pkg::*;
    localparam logic [7:0] A_CTL = {`CCA_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_MOD = {`CCA_IDX_MODE, 2'b00};
    localparam logic [7:0] A_HI  = {`CCA_IDX_CNT_HI, 2'b00};
    localparam logic [7:0] A_LO  = {`CCA_IDX_CNT_LO, 2'b00};
    logic        ref_clk = 1'b0; // 40 mhz host clock
    logic        rst     = 1'b1; // asynchronous, held four cycles
    cca_avreq_s  req     = '0;   // host request bundle
    logic [31:0] rdata;          // slave read answer
    logic        wreq;           // slave wait request
    logic        pulse   = 1'b0; // converter pulse pin
    logic [1:0]  mode    = 2'h0; // converter mode pin
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    logic [15:0] cnt = 16'h0;    // expected count
    logic [1:0]  sel = 2'h0;     // expected prescale select
    logic [31:0] d;              // scratch read value
    logic [31:0] e;              // scratch second read value
    int          n;              // pulses in a burst

    always #12.5 ref_clk = ~ref_clk;

    cca_charge_readout cca_charge_readout_inst (
        .ref_clk(ref_clk), .rst(rst), .av_req(req),
        .av_readdata(rdata), .av_waitrequest(wreq),
        .conv_pulse(pulse), .conv_mode(mode));

    // compare and count
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict; the only place the run ends
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one avalon transfer, sampled on rising edges only: just after an
    // edge the flops have not moved yet, so we read what it sampled.
    // hold keeps the request up that many cycles, ending on an answer.
    task automatic bus(input logic rd, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] be,
                       input int hold, output logic [31:0] v);
        int  k;
        logic ok;
        k  = 0;
        ok = 1'b0;
        v  = 32'h0;
        @(posedge ref_clk);
        req <= '{address: a, read: rd, write: !rd, writedata: wd,
                 byteenable: be};
        while ((!ok || k < hold) && k < 200)
        begin
            @(posedge ref_clk);
            k++;
            ok = (wreq === 1'b0);
            if (ok)
                v = rdata;
        end
        if (!ok)
            check("bus answer", 32'h0, 32'h1);
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    // n pulses, seven cycles apart and each three cycles high, then settle
    task automatic pulses(input int cnt_p);
        repeat (cnt_p)
        begin
            @(posedge ref_clk) pulse <= 1'b1;
            repeat (3) @(posedge ref_clk);
            pulse <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
    endtask

    // expected gain of a burst: one count per group of 2**s
    function automatic logic [15:0] gain(int p, logic [1:0] s);
        return 16'(p >> s);
    endfunction

    // high, low and mode, against the expected count and mode pin
    task automatic chk_count(string what);
        logic [31:0] h;
        logic [31:0] l;
        logic [31:0] md;
        bus(1'b1, A_HI, 32'h0, 4'h1, 0, h);
        bus(1'b1, A_LO, 32'h0, 4'h1, 0, l);
        bus(1'b1, A_MOD, 32'h0, 4'h1, 0, md);
        check({what, " high"}, h, {24'h0, cnt[15:8]});
        check({what, " low"}, l, {24'h0, cnt[7:0]});
        check({what, " mode"}, md, {30'h0, mode});
    endtask

    // watchdog, well beyond the roughly 2700 to 3700 cycles of the tests
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("watchdog expired");
        wrap_up();
    end

    initial
    begin
        void'($urandom(90216));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        chk_count("reset");
        bus(1'b1, A_CTL, 32'h0, 4'h1, 0, d);
        check("reset ctrl", d, 32'h0);
        $display("test reset done");
        // every mode code, past the four-edge resync lag
        for (int m = 0; m < 4; m++)
        begin
            mode <= 2'(m);
            repeat (6) @(posedge ref_clk);
            bus(1'b1, A_MOD, 32'h0, 4'h1, 0, d);
            check("mode", d, 32'(m));
        end
        mode <= 2'h1;
        repeat (6) @(posedge ref_clk);
        // pin moves while the mode read stands
        fork
            bus(1'b1, A_MOD, 32'h0, 4'h1, 12, d);
            begin
                repeat (3) @(posedge ref_clk);
                mode <= 2'h2;
            end
        join
        check("held mode", d, 32'h1);
        repeat (6) @(posedge ref_clk);
        bus(1'b1, A_MOD, 32'h0, 4'h1, 0, d);
        check("mode after hold", d, 32'h2);
        $display("test mode done");
        // each prescale in turn then two random ones, random bursts in whole groups of eight
        for (int i = 0; i < 6; i++)
        begin
            sel = (i < 4) ? 2'(i) : 2'($urandom % 4);
            n   = 8 * (1 + $urandom % 4);
            bus(1'b0, A_CTL, {30'h0, sel}, 4'h1, 0, d);
            bus(1'b1, A_CTL, 32'h0, 4'h1, 0, d);
            check("ctrl", d, {30'h0, sel});
            // mode pin left alone while counting
            pulses(n);
            cnt = cnt + gain(n, sel);
            chk_count("burst");
        end
        // carry into the high byte
        sel = 2'h0;
        bus(1'b0, A_CTL, 32'h0, 4'h1, 0, d);
        pulses(264);
        cnt = cnt + gain(264, sel);
        chk_count("carry");
        $display("test count done");
        // shadow keeps the low byte of the high read
        bus(1'b1, A_HI, 32'h0, 4'h1, 0, d);
        check("shadow high", d, {24'h0, cnt[15:8]});
        n = {24'h0, cnt[7:0]};
        pulses(8);
        cnt = cnt + gain(8, sel);
        bus(1'b1, A_LO, 32'h0, 4'h1, 0, d);
        bus(1'b1, A_LO, 32'h0, 4'h1, 0, e);
        check("shadow low", d, 32'(n));
        check("shadow again", e, 32'(n));
        chk_count("after shadow");
        $display("test shadow done");
        // pulses during a standing count read are lost
        fork
            bus(1'b1, A_HI, 32'h0, 4'h1, 80, d);
            begin
                repeat (4) @(posedge ref_clk);
                pulses(8);
            end
        join
        chk_count("frozen");
        pulses(8);
        cnt = cnt + gain(8, sel);
        chk_count("resumed");
        $display("test freeze done");
        // writes to read-only places, a lane-less control write
        bus(1'b0, A_HI, $urandom, 4'hf, 0, d);
        bus(1'b0, A_LO, $urandom, 4'hf, 0, d);
        bus(1'b0, A_MOD, $urandom, 4'hf, 0, d);
        chk_count("ro write");
        bus(1'b1, A_MOD, 32'h0, 4'h1, 0, d);
        check("ro mode", d, 32'h2);
        bus(1'b0, A_CTL, 32'h3, 4'h0, 0, d);
        bus(1'b1, A_CTL, 32'h0, 4'h1, 0, d);
        check("ctrl no lane", d, 32'h0);
        bus(1'b1, 8'h7c, 32'h0, 4'h1, 0, d);
        check("unmapped", d, 32'h0);
        $display("test writes done");
        wrap_up();
    end
endmodule // cca_charge_readout_tb
